// ===== hw/ipu_codec.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Codec switches in only when the transceiver mode field selects infrared.
// - Pin levels are the inverse of the infrared pulse sent or received.
// - A chosen event channel replaces the receive pin as decoder input.
// - Transmit length zero gives pulses of 3/16 bit period.
// - Transmit length 1 to 254 gives pulses of that many clocks.
// - Fixed length pulses start on the bit clock rising edge.
// - Transmit length 255 passes transmit and receive through unchanged.
// - Length settings do nothing unless infrared mode is selected.
// - Receive length zero means no receive filtering.
// - Receive length x accepts a level after x+1 equal samples.
// - Accepted high pulse decodes as 0, short pulses decode as 1.
// - Selector 0000 means no event, 1nnn means event channel n.
module ipu_codec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipu_pkg::IPU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] communication_mode,
  input wire logic usart_tx,
  output logic usart_rx,
  input wire logic bit_tick,
  input wire logic sample_tick,
  input wire logic [7:0] event_in,
  input wire logic rx_pin,
  output logic tx_pin
);

  ipu_pkg::ipu_state_t r_reg;
  ipu_pkg::ipu_state_t r_next;

  logic ir_mode;
  logic coded;
  logic ev_on;
  logic rx_src;
  logic [1:0] idx;
  logic mapped;

  // ==========================================
  // Routing decisions
  assign ir_mode = communication_mode == ipu_pkg::IPU_MODE_IR;
  assign coded = r_reg.txpl != ipu_pkg::IPU_TXPL_PASS;
  assign ev_on = r_reg.ev_select[ipu_pkg::IPU_EV_EN_BIT];
  assign rx_src = ev_on ? event_in[r_reg.ev_select[2:0]] : rx_pin;
  assign idx = paddr[ipu_pkg::IPU_ADDR_W-1:2];
  assign mapped = (paddr[1:0] == ipu_pkg::IPU_BYTE_OFS) &&
                  (idx == ipu_pkg::IPU_IDX_CTRL || idx == ipu_pkg::IPU_IDX_TXPL ||
                   idx == ipu_pkg::IPU_IDX_RXPL);

  always_comb begin
    logic s;
    logic [8:0] need;
    s = 1'b0;
    need = 9'h000;
    r_next = r_reg;
    // ==========================================
    // APB slave: ready in first access cycle
    r_next.ready = psel && !penable;
    if (psel && !penable) begin
      r_next.slverr = !mapped;
      case (idx)
        ipu_pkg::IPU_IDX_CTRL: r_next.rdata = {4'h0, r_reg.ev_select};
        ipu_pkg::IPU_IDX_TXPL: r_next.rdata = r_reg.txpl;
        ipu_pkg::IPU_IDX_RXPL: r_next.rdata = r_reg.rxpl;
        default: r_next.rdata = 8'h00;
      endcase
      if (!mapped) begin
        r_next.rdata = 8'h00;
      end
    end
    if (psel && penable && r_reg.ready && pwrite && mapped) begin
      case (idx)
        ipu_pkg::IPU_IDX_CTRL: r_next.ev_select = pwdata[3:0];
        ipu_pkg::IPU_IDX_TXPL: r_next.txpl = pwdata[7:0];
        ipu_pkg::IPU_IDX_RXPL: r_next.rxpl = pwdata[7:0];
        default: r_next.ev_select = r_reg.ev_select;
      endcase
    end
    // ==========================================
    // Transmit pulse generator
    if (!r_reg.tx_on) begin
      if (bit_tick && !usart_tx && coded) begin
        r_next.tx_on = 1'b1;
        r_next.tx_cnt = (r_reg.txpl == ipu_pkg::IPU_TXPL_316) ? 8'h00 : 8'h01;
      end
    end else if (r_reg.txpl == ipu_pkg::IPU_TXPL_316) begin
      if (sample_tick) begin
        r_next.tx_cnt = r_reg.tx_cnt + 8'h01;
        if (r_reg.tx_cnt + 8'h01 >= {4'h0, ipu_pkg::IPU_SIXTEENTHS}) begin
          r_next.tx_on = 1'b0;
        end
      end
    end else if (r_reg.tx_cnt >= r_reg.txpl) begin
      r_next.tx_on = 1'b0;
    end else begin
      r_next.tx_cnt = r_reg.tx_cnt + 8'h01;
    end
    if (!ir_mode || !coded) begin
      r_next.tx_on = 1'b0;
      r_next.tx_pin = usart_tx;
    end else begin
      r_next.tx_pin = !r_next.tx_on;
    end
    // ==========================================
    // Receive filter, one sample per clock
    s = !rx_src;
    need = {1'b0, r_reg.rxpl} + ipu_pkg::IPU_ONE9;
    if (s != r_reg.f_last) begin
      r_next.f_cnt = ipu_pkg::IPU_ONE9;
    end else if (r_reg.f_cnt < need) begin
      r_next.f_cnt = r_reg.f_cnt + ipu_pkg::IPU_ONE9;
    end
    r_next.f_last = s;
    if (r_reg.rxpl == ipu_pkg::IPU_RXPL_OFF || r_next.f_cnt >= need) begin
      r_next.f_lvl = s;
    end
    if (!ir_mode) begin
      r_next.urx = rx_pin;
    end else if (!coded) begin
      r_next.urx = rx_src;
    end else begin
      r_next.urx = !r_next.f_lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{
        ev_select: ipu_pkg::IPU_EVSRC_RST,
        txpl: ipu_pkg::IPU_TXPL_RST,
        rxpl: ipu_pkg::IPU_RXPL_RST,
        rdata: 8'h00,
        ready: 1'b0,
        slverr: 1'b0,
        tx_pin: 1'b1,
        urx: 1'b1,
        tx_on: 1'b0,
        tx_cnt: 8'h00,
        f_cnt: 9'h000,
        f_last: 1'b0,
        f_lvl: 1'b0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = {24'h000000, r_reg.rdata};
  assign pready = r_reg.ready;
  assign pslverr = r_reg.slverr;
  assign tx_pin = r_reg.tx_pin;
  assign usart_rx = r_reg.urx;

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_pass;
    !ir_mode |=> tx_pin == $past(usart_tx) && usart_rx == $past(rx_pin);
  endproperty
  a_idle_pass: assert property (p_idle_pass) else $error("codec not bypassed outside ir mode");

  property p_tx_pass;
    ir_mode && !coded |=> tx_pin == $past(usart_tx);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx not passed through");

  property p_fix_start;
    ir_mode && coded && r_reg.txpl != 8'h00 && bit_tick && !usart_tx && !r_reg.tx_on |=> !tx_pin;
  endproperty
  a_fix_start: assert property (p_fix_start) else $error("pulse not started at bit clock");

  property p_fix_len;
    ir_mode && r_reg.txpl == 8'h02 && $fell(tx_pin) |-> !tx_pin ##1 !tx_pin ##1 tx_pin;
  endproperty
  a_fix_len: assert property (p_fix_len) else $error("fixed pulse length wrong");

  property p_316_end;
    ir_mode && r_reg.txpl == 8'h00 && r_reg.tx_on && r_reg.tx_cnt == 8'h02 && sample_tick |=> tx_pin;
  endproperty
  a_316_end: assert property (p_316_end) else $error("3/16 pulse not ended");

  property p_rx_nofilt;
    ir_mode && coded && r_reg.rxpl == 8'h00 && !ev_on |=> usart_rx == $past(rx_pin);
  endproperty
  a_rx_nofilt: assert property (p_rx_nofilt) else $error("unfiltered rx wrong");

  property p_rx_event;
    ir_mode && coded && r_reg.rxpl == 8'h00 && ev_on |=> usart_rx == $past(event_in[r_reg.ev_select[2:0]]);
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("event input not used");

  property p_rx_filt;
    ir_mode && coded && r_reg.rxpl == 8'h01 && !ev_on && rx_pin == $past(rx_pin) |=> usart_rx == $past(rx_pin);
  endproperty
  a_rx_filt: assert property (p_rx_filt) else $error("filtered level not accepted");

  property p_rx_glitch;
    ir_mode && coded && r_reg.rxpl == 8'h01 && !ev_on && rx_pin != $past(rx_pin) |=> $stable(usart_rx);
  endproperty
  a_rx_glitch: assert property (p_rx_glitch) else $error("short pulse not discarded");

  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready in access cycle");

  // ==========================================
  // Register bus checks
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("ready longer than one cycle");

  property p_apb_err;
    psel && !penable && !mapped |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");

  property p_apb_ok;
    psel && !penable && mapped |=> !pslverr;
  endproperty
  a_apb_ok: assert property (p_apb_ok) else $error("mapped access refused");

  property p_err_stands;
    !(psel && !penable) |=> $stable(pslverr);
  endproperty
  a_err_stands: assert property (p_err_stands) else $error("error flag changed outside setup");

  property p_rdata_stands;
    !(psel && !penable) |=> $stable(prdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed outside setup");

  property p_wr_ctrl;
    psel && penable && pready && pwrite && mapped && idx == ipu_pkg::IPU_IDX_CTRL |=>
      r_reg.ev_select == $past(pwdata[3:0]);
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");

  property p_wr_txpl;
    psel && penable && pready && pwrite && mapped && idx == ipu_pkg::IPU_IDX_TXPL |=>
      r_reg.txpl == $past(pwdata[7:0]);
  endproperty
  a_wr_txpl: assert property (p_wr_txpl) else $error("tx length write lost");

  property p_wr_rxpl;
    psel && penable && pready && pwrite && mapped && idx == ipu_pkg::IPU_IDX_RXPL |=>
      r_reg.rxpl == $past(pwdata[7:0]);
  endproperty
  a_wr_rxpl: assert property (p_wr_rxpl) else $error("rx filter write lost");

  property p_wr_drop;
    psel && penable && pready && pwrite && !mapped |=>
      $stable(r_reg.txpl) && $stable(r_reg.rxpl) && $stable(r_reg.ev_select);
  endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("unmapped write landed");

  property p_rd_ctrl;
    psel && !penable && mapped && idx == ipu_pkg::IPU_IDX_CTRL |=>
      prdata == {28'h0000000, $past(r_reg.ev_select)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  // ==========================================
  // Link checks
  property p_tx_one;
    ir_mode && r_reg.txpl == 8'h01 && $fell(tx_pin) |=> tx_pin;
  endproperty
  a_tx_one: assert property (p_tx_one) else $error("one clock pulse too long");

  property p_316_hold;
    ir_mode && r_reg.txpl == ipu_pkg::IPU_TXPL_316 && r_reg.tx_on && !sample_tick |=> !tx_pin;
  endproperty
  a_316_hold: assert property (p_316_hold) else $error("3/16 pulse cut short");

  property p_tx_idle;
    ir_mode && coded && !r_reg.tx_on && !bit_tick |=> tx_pin;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx pin low without pulse");

  property p_rx_pass;
    ir_mode && !coded |=> usart_rx == $past(rx_src);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx not passed through");

  c_fix_pulse: cover property (ir_mode && r_reg.txpl == 8'h04 && $fell(tx_pin));
  c_316_pulse: cover property (ir_mode && r_reg.txpl == 8'h00 && $rose(tx_pin));
  c_event_rx: cover property (ir_mode && ev_on && $fell(usart_rx));
  c_apb_write: cover property (psel && penable && pready && pwrite);
  c_rx_filtered: cover property (ir_mode && coded && r_reg.rxpl == 8'hFF && $fell(usart_rx));

endmodule : ipu_codec
`default_nettype wire

// ===== hw/ipu_pkg.sv
package ipu_pkg;
  // ==========================================
  // Register map (word index, byte address = 4 * index)
  localparam int IPU_ADDR_W = 4;
  localparam logic [1:0] IPU_IDX_CTRL = 2'h0;
  localparam logic [1:0] IPU_IDX_TXPL = 2'h1;
  localparam logic [1:0] IPU_IDX_RXPL = 2'h2;
  localparam logic [1:0] IPU_BYTE_OFS = 2'h0;
  localparam logic [7:0] IPU_TXPL_RST = 8'h00;
  localparam logic [7:0] IPU_RXPL_RST = 8'h00;
  localparam logic [3:0] IPU_EVSRC_RST = 4'h0;
  // ==========================================
  // Field encodings
  localparam logic [1:0] IPU_MODE_IR = 2'h2;
  localparam logic [7:0] IPU_TXPL_316 = 8'h00;
  localparam logic [7:0] IPU_TXPL_PASS = 8'hFF;
  localparam logic [7:0] IPU_RXPL_OFF = 8'h00;
  localparam int IPU_EV_EN_BIT = 3;
  localparam logic [3:0] IPU_SIXTEENTHS = 4'h3;
  localparam logic [8:0] IPU_ONE9 = 9'h001;
  // ==========================================
  // Whole module state
  typedef struct packed {
    logic [3:0] ev_select;
    logic [7:0] txpl;
    logic [7:0] rxpl;
    logic [7:0] rdata;
    logic ready;
    logic slverr;
    logic tx_pin;
    logic urx;
    logic tx_on;
    logic [7:0] tx_cnt;
    logic [8:0] f_cnt;
    logic f_last;
    logic f_lvl;
  } ipu_state_t;
endpackage : ipu_pkg

// ===== tb/ipu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Transceiver timing: 16x sample ticks, bit tick on every 16th
module ipu_far_side (
  input wire logic pclk,
  input wire logic presetn,
  output logic sample_tick,
  output logic bit_tick
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign sample_tick = (cnt_reg[3:0] == 4'hF);
  assign bit_tick = (cnt_reg == 8'hFF);
endmodule : ipu_far_side
`default_nettype wire

// ===== tb/test_ipu_codec.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", s, e, g); end end
module test_ipu_codec;
  typedef struct packed {logic [1:0] m; logic [3:0] c; logic [7:0] t; logic [7:0] r; logic [1:0] s;
    logic [8:0] k; logic x;} ipu_rx_case_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic usart_tx = 1'h1, rx_pin = 1'h1, pready, pslverr, usart_rx, bit_tick, sample_tick, tx_pin, er, got, tick_d;
  logic [3:0] paddr = 4'h0;
  logic [1:0] communication_mode = 2'h0;
  logic [7:0] event_in = 8'hFF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] tl [5] = '{8'h00, 8'h01, 8'h02, 8'hFE, 8'hFF};
  int te [5] = '{48, 1, 2, 254, 300};
  int n_errors = 0, comparisons = 0, len;
  ipu_rx_case_t rc [10] = '{
    '{2'h2, 4'h0, 8'h00, 8'h01, 2'h1, 9'h001, 1'h0},
    '{2'h2, 4'h0, 8'h00, 8'h01, 2'h1, 9'h002, 1'h1},
    '{2'h2, 4'h0, 8'h00, 8'h00, 2'h1, 9'h001, 1'h1},
    '{2'h2, 4'hD, 8'h00, 8'h00, 2'h1, 9'h004, 1'h0},
    '{2'h2, 4'hD, 8'h00, 8'h00, 2'h2, 9'h001, 1'h1},
    '{2'h2, 4'h5, 8'h00, 8'h00, 2'h1, 9'h001, 1'h1},
    '{2'h0, 4'h0, 8'h00, 8'h03, 2'h1, 9'h001, 1'h1},
    '{2'h2, 4'h0, 8'hFF, 8'h03, 2'h1, 9'h001, 1'h1},
    '{2'h2, 4'h0, 8'h00, 8'hFF, 2'h1, 9'h0FF, 1'h0},
    '{2'h2, 4'h0, 8'h00, 8'hFF, 2'h1, 9'h100, 1'h1}};
  always #20 pclk = ~pclk;
  always @(posedge pclk) tick_d <= bit_tick;
  ipu_far_side ipu_far_side_i (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick), .bit_tick(bit_tick));
  ipu_codec ipu_codec_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .communication_mode(communication_mode), .usart_tx(usart_tx), .usart_rx(usart_rx), .bit_tick(bit_tick),
    .sample_tick(sample_tick), .event_in(event_in), .rx_pin(rx_pin), .tx_pin(tx_pin));
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        report_and_stop();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic tx_pulse(input logic sync);
    int n;
    len = 0;
    for (n = 0; sync && n < 300 && tx_pin !== 1'h1; n++) begin
      @(posedge pclk);
    end
    if (n >= 300) begin
      n_errors++;
      report_and_stop();
    end
    for (n = 0; n < 600 && tx_pin !== 1'h0; n++) begin
      @(posedge pclk);
    end
    if (n >= 600) begin
      n_errors++;
      report_and_stop();
    end
    if (sync) `CHK("pulse start", 1'h1, tick_d)
    while (tx_pin === 1'h0 && len < 300) begin
      len++;
      @(posedge pclk);
    end
  endtask : tx_pulse
  task automatic rx_pulse(input logic [1:0] s, input int k);
    got = 1'h0;
    rx_pin <= !s[0];
    event_in[5] <= !s[1];
    repeat (k) @(posedge pclk);
    rx_pin <= 1'h1;
    event_in <= 8'hFF;
    repeat (4) begin
      @(posedge pclk);
      got = got | (usart_rx === 1'h0);
    end
  endtask : rx_pulse
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 4'(i * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
      `CHK("slverr", 1'(i == 3), er)
    end
    apb(1'h1, 4'h0, 32'h0000000B);
    apb(1'h0, 4'h0, 32'h0);
    `CHK("control", 32'h0000000B, rd)
    $display("Test registers done");
    // ==========================================
    // Transmit coding
    apb(1'h1, 4'h4, 32'h00000002);
    usart_tx <= 1'h0;
    tx_pulse(1'h0);
    `CHK("tx plain", 300, len)
    communication_mode <= 2'h2;
    foreach (tl[i]) begin
      apb(1'h1, 4'h4, {24'h0, tl[i]});
      tx_pulse(tl[i] != 8'hFF);
      `CHK("tx pulse", te[i], len)
    end
    $display("Test transmit done");
    // ==========================================
    // Receive decoding
    usart_tx <= 1'h1;
    foreach (rc[i]) begin
      communication_mode <= rc[i].m;
      apb(1'h1, 4'h0, {28'h0, rc[i].c});
      apb(1'h1, 4'h4, {24'h0, rc[i].t});
      apb(1'h1, 4'h8, {24'h0, rc[i].r});
      rx_pulse(rc[i].s, rc[i].k);
      `CHK("rx decode", rc[i].x, got)
    end
    $display("Test receive done");
    report_and_stop();
  end
endmodule : test_ipu_codec
`default_nettype wire
